// File: design/aux_digital_io_strobe.sv
// Strobe, phase sync, user inputs and user outputs with APB registers
`timescale 1ns/100ps
module aux_digital_io_strobe (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_transient_start,
  input wire logic i_relay_change,
  input wire logic i_param_change,
  input wire logic i_phase_a_zero,
  input wire logic [2:0] i_user_input,
  input wire logic i_output_enabled,
  input wire logic i_phase_tie_config,
  input wire logic i_fault,
  input wire logic i_transient_active,
  input wire logic i_program_running,
  input wire logic i_remote,
  input wire logic i_xfmr_coupling,
  input wire logic i_tie_relay_cmd,
  input wire logic i_xfmr_relay_cmd,
  output logic o_strobe,
  output logic o_phase_sync,
  output logic [2:0] o_input_rise,
  output logic [2:0] o_input_fall,
  output logic [3:0] o_user_output
);
  logic [2:0] stb_en_reg, stb_en_next;
  logic [2:0] sync_ctrl_reg, sync_ctrl_next;
  logic [16:0] sync_width_reg, sync_width_next;
  logic [7:0] filt_reg, filt_next;
  logic [31:0] out_ctrl_reg, out_ctrl_next;
  logic pready_reg, pready_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic access;
  logic [31:0] rd_mux;
  logic [2:0] in_filt_state;
  logic [3:0] out_state;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  assign access = i_psel && i_penable;

  // Register file; one wait-free answer in the access phase
  always_comb
  begin
    stb_en_next = stb_en_reg;
    sync_ctrl_next = sync_ctrl_reg;
    sync_width_next = sync_width_reg;
    filt_next = filt_reg;
    out_ctrl_next = out_ctrl_reg;
    pready_next = i_psel && !i_penable;
    prdata_next = 32'h00000000;
    pslverr_next = 1'b0;
    if (i_psel && !i_penable)
      prdata_next = rd_mux;
    if (access && i_pwrite && pready_reg)
    begin
      case (i_paddr)
        aux_dio_pkg::ADDR_STROBE_CTRL: stb_en_next = i_pwdata[2:0];
        aux_dio_pkg::ADDR_SYNC_CTRL: sync_ctrl_next = i_pwdata[2:0];
        aux_dio_pkg::ADDR_SYNC_WIDTH:
        begin
          // Out-of-range widths clamp to the legal span
          if (i_pwdata[31:17] == 15'h0000 &&
              i_pwdata[16:0] < aux_dio_pkg::SYNC_MIN_US)
            sync_width_next = aux_dio_pkg::SYNC_MIN_US;
          else if (i_pwdata[31:17] != 15'h0000 ||
                   i_pwdata[16:0] > aux_dio_pkg::SYNC_MAX_US)
            sync_width_next = aux_dio_pkg::SYNC_MAX_US;
          else
            sync_width_next = i_pwdata[16:0];
        end
        aux_dio_pkg::ADDR_IN_FILTER: filt_next = i_pwdata[7:0];
        aux_dio_pkg::ADDR_OUT_CTRL: out_ctrl_next = i_pwdata;
        default: pslverr_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      stb_en_reg <= 3'h0;
      sync_ctrl_reg <= 3'h0;
      sync_width_reg <= aux_dio_pkg::SYNC_WIDTH_RST;
      filt_reg <= aux_dio_pkg::FILTER_RST;
      out_ctrl_reg <= aux_dio_pkg::OUT_CTRL_RST;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      stb_en_reg <= stb_en_next;
      sync_ctrl_reg <= sync_ctrl_next;
      sync_width_reg <= sync_width_next;
      filt_reg <= filt_next;
      out_ctrl_reg <= out_ctrl_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Read mux registered during setup so data is ready with pready
  always_comb
  begin
    case (i_paddr)
      aux_dio_pkg::ADDR_STROBE_CTRL: rd_mux = {29'h0, stb_en_reg};
      aux_dio_pkg::ADDR_SYNC_CTRL: rd_mux = {29'h0, sync_ctrl_reg};
      aux_dio_pkg::ADDR_SYNC_WIDTH: rd_mux = {15'h0, sync_width_reg};
      aux_dio_pkg::ADDR_IN_FILTER: rd_mux = {24'h0, filt_reg};
      aux_dio_pkg::ADDR_IN_STATUS: rd_mux = {29'h0, in_filt_state};
      aux_dio_pkg::ADDR_OUT_CTRL: rd_mux = out_ctrl_reg;
      aux_dio_pkg::ADDR_OUT_STATE: rd_mux = {28'h0, out_state};
      default: rd_mux = 32'h00000000;
    endcase
  end
  assign o_pready = pready_reg;
  assign o_prdata = prdata_reg;
  assign o_pslverr = pslverr_reg;

  // Synchronise all event pins, two stages each
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw, meta_reg, sync_reg, prev_reg;
  assign pin_raw = {i_user_input, i_phase_a_zero, i_param_change,
                    i_relay_change, i_transient_start};
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  logic ev_tran, ev_relay, ev_param, ev_zero;
  assign ev_tran = sync_reg[0] && !prev_reg[0];
  assign ev_relay = sync_reg[1] && !prev_reg[1];
  assign ev_param = sync_reg[2] && !prev_reg[2];
  assign ev_zero = sync_reg[3] && !prev_reg[3];

  // Strobe timer; a new trigger restarts it
  logic [23:0] stb_cnt_reg, stb_cnt_next;
  logic strobe_reg, strobe_next;
  always_comb
  begin
    stb_cnt_next = stb_cnt_reg;
    if (ev_relay && stb_en_reg[aux_dio_pkg::STB_EN_RELAY] ||
        ev_param && stb_en_reg[aux_dio_pkg::STB_EN_PARAM])
      stb_cnt_next = aux_dio_pkg::STB_LONG_CYC;
    else if (ev_tran && stb_en_reg[aux_dio_pkg::STB_EN_TRAN])
      stb_cnt_next = aux_dio_pkg::STB_SHORT_CYC;
    else if (stb_cnt_reg != 24'h000000)
      stb_cnt_next = stb_cnt_reg - 24'h000001;
    strobe_next = stb_cnt_next != 24'h000000;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      stb_cnt_reg <= 24'h000000;
      strobe_reg <= 1'b0;
    end
    else
    begin
      stb_cnt_reg <= stb_cnt_next;
      strobe_reg <= strobe_next;
    end
  end
  assign o_strobe = strobe_reg;

  // Phase sync: microsecond prescaler plus width counter
  logic [6:0] us_cnt_reg, us_cnt_next;
  logic [16:0] sw_cnt_reg, sw_cnt_next;
  logic sq_reg, sq_next;
  logic sync_out_reg, sync_out_next;
  always_comb
  begin
    us_cnt_next = us_cnt_reg;
    sw_cnt_next = sw_cnt_reg;
    sq_next = sq_reg;
    if (ev_zero)
    begin
      us_cnt_next = 7'h00;
      sw_cnt_next = sync_width_reg;
      sq_next = ~sq_reg;
    end
    else if (sw_cnt_reg != 17'h00000)
    begin
      if (us_cnt_reg == aux_dio_pkg::US_CYC - 7'h01)
      begin
        us_cnt_next = 7'h00;
        sw_cnt_next = sw_cnt_reg - 17'h00001;
      end
      else
        us_cnt_next = us_cnt_reg + 7'h01;
    end
    // Auto mode toggles every zero crossing: one period per two crossings
    if (!sync_ctrl_reg[aux_dio_pkg::SYNC_EN])
      sync_out_next = sync_ctrl_reg[aux_dio_pkg::SYNC_POL];
    else if (sync_ctrl_reg[aux_dio_pkg::SYNC_AUTO])
      sync_out_next = sq_next ^ sync_ctrl_reg[aux_dio_pkg::SYNC_POL];
    else
      sync_out_next = (sw_cnt_next != 17'h00000) ^
                      sync_ctrl_reg[aux_dio_pkg::SYNC_POL];
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      us_cnt_reg <= 7'h00;
      sw_cnt_reg <= 17'h00000;
      sq_reg <= 1'b0;
      sync_out_reg <= 1'b0;
    end
    else
    begin
      us_cnt_reg <= us_cnt_next;
      sw_cnt_reg <= sw_cnt_next;
      sq_reg <= sq_next;
      sync_out_reg <= sync_out_next;
    end
  end
  assign o_phase_sync = sync_out_reg;

  // User inputs: filter needs a stable level for filt_reg+1 cycles
  logic [2:0] rise_reg, fall_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_in
      logic [7:0] fc_reg, fc_next;
      logic st_reg, st_next;
      logic rise_next, fall_next;
      always_comb
      begin
        fc_next = 8'h00;
        st_next = st_reg;
        if (sync_reg[4+gi] != st_reg)
        begin
          fc_next = fc_reg + 8'h01;
          if (fc_reg >= filt_reg)
          begin
            fc_next = 8'h00;
            st_next = sync_reg[4+gi];
          end
        end
        rise_next = st_next && !st_reg;
        fall_next = !st_next && st_reg;
      end
      always_ff @(posedge i_clk_sys)
      begin
        if (i_rst)
        begin
          fc_reg <= 8'h00;
          st_reg <= 1'b0;
          rise_reg[gi] <= 1'b0;
          fall_reg[gi] <= 1'b0;
        end
        else
        begin
          fc_reg <= fc_next;
          st_reg <= st_next;
          rise_reg[gi] <= rise_next;
          fall_reg[gi] <= fall_next;
        end
      end
      assign in_filt_state[gi] = st_reg;
    end
  endgenerate
  assign o_input_rise = rise_reg;
  assign o_input_fall = fall_reg;

  // User outputs: source select then invert
  logic [3:0] uo_reg;
  genvar go;
  generate
    for (go = 0; go < 4; go++)
    begin : g_out
      logic [7:0] f;
      logic src_val, uo_next;
      assign f = out_ctrl_reg[go*8 +: 8];
      always_comb
      begin
        case (f[3:0])
          aux_dio_pkg::SRC_GP: src_val = f[aux_dio_pkg::OUT_GPV];
          aux_dio_pkg::SRC_OUT_EN: src_val = i_output_enabled;
          aux_dio_pkg::SRC_PHASE_TIE: src_val = i_phase_tie_config;
          aux_dio_pkg::SRC_FAULT: src_val = i_fault;
          aux_dio_pkg::SRC_TRANSIENT: src_val = i_transient_active;
          aux_dio_pkg::SRC_PROGRAM: src_val = i_program_running;
          aux_dio_pkg::SRC_REMOTE: src_val = i_remote;
          aux_dio_pkg::SRC_COUPLING: src_val = i_xfmr_coupling;
          aux_dio_pkg::SRC_TIE_RELAY: src_val = i_tie_relay_cmd;
          aux_dio_pkg::SRC_XFMR_RELAY: src_val = i_xfmr_relay_cmd;
          default: src_val = 1'b0;
        endcase
        uo_next = src_val ^ f[aux_dio_pkg::OUT_INV];
      end
      always_ff @(posedge i_clk_sys)
      begin
        if (i_rst)
          uo_reg[go] <= 1'b0;
        else
          uo_reg[go] <= uo_next;
      end
    end
  endgenerate
  assign o_user_output = uo_reg;
  assign out_state = uo_reg;

  // Assertions
  stb_long_a: assert property (stb_cnt_reg == 24'h000001 &&
    !ev_relay && !ev_param && !ev_tran |=> !o_strobe)
    else $error("strobe did not end");
  stb_start_a: assert property (ev_tran && stb_en_reg[0]
    |=> o_strobe) else $error("transient strobe missing");
  stb_off_a: assert property (stb_en_reg == 3'h0
    && stb_cnt_reg == 24'h000000 |=> !o_strobe)
    else $error("strobe without enable");
  relay_len_a: assert property (ev_relay && stb_en_reg[1]
    |=> stb_cnt_reg == aux_dio_pkg::STB_LONG_CYC)
    else $error("relay strobe length wrong");
  param_len_a: assert property (ev_param && stb_en_reg[2]
    |=> stb_cnt_reg == aux_dio_pkg::STB_LONG_CYC)
    else $error("param strobe length wrong");
  tran_len_a: assert property (ev_tran && stb_en_reg[0]
    && !ev_relay && !ev_param
    |=> stb_cnt_reg == aux_dio_pkg::STB_SHORT_CYC)
    else $error("short strobe wrong");
  sync_width_a: assert property (sync_width_reg >= 17'h00003
    && sync_width_reg <= 17'h186A0)
    else $error("sync width out of range");
  sync_zero_a: assert property (ev_zero && sync_ctrl_reg == 3'h1
    |=> ##1 o_phase_sync) else $error("sync pulse missing");
  out_inv_a: assert property (out_ctrl_reg[3:0] == 4'h1
    && $stable(out_ctrl_reg) |=> o_user_output[0] ==
    ($past(i_output_enabled) ^ $past(out_ctrl_reg[4])))
    else $error("output source wrong");
endmodule

// File: design/aux_dio_pkg.sv
// Constants and register map for the auxiliary digital I/O block
package aux_dio_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned STB_SHORT_US = 190;
  localparam int unsigned STB_LONG_US = 2000;
  localparam logic [23:0] STB_SHORT_CYC = 24'(STB_SHORT_US * CLK_MHZ);
  localparam logic [23:0] STB_LONG_CYC = 24'(STB_LONG_US * CLK_MHZ);
  localparam logic [16:0] SYNC_MIN_US = 17'h00003;
  localparam logic [16:0] SYNC_MAX_US = 17'h186A0;
  localparam logic [6:0] US_CYC = 7'(CLK_MHZ);
  // Register byte addresses
  localparam logic [7:0] ADDR_STROBE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h04;
  localparam logic [7:0] ADDR_SYNC_WIDTH = 8'h08;
  localparam logic [7:0] ADDR_IN_FILTER = 8'h0C;
  localparam logic [7:0] ADDR_IN_STATUS = 8'h10;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h14;
  localparam logic [7:0] ADDR_OUT_STATE = 8'h18;
  // Field positions
  localparam int STB_EN_TRAN = 0;
  localparam int STB_EN_RELAY = 1;
  localparam int STB_EN_PARAM = 2;
  localparam int SYNC_EN = 0;
  localparam int SYNC_POL = 1;
  localparam int SYNC_AUTO = 2;
  // Output control: per output 8 bits, [3:0] source, [4] invert, [5] gp value
  localparam int OUT_FIELD_W = 8;
  localparam int OUT_INV = 4;
  localparam int OUT_GPV = 5;
  typedef enum logic [3:0] {
    SRC_GP, SRC_OUT_EN, SRC_PHASE_TIE, SRC_FAULT, SRC_TRANSIENT,
    SRC_PROGRAM, SRC_REMOTE, SRC_COUPLING, SRC_TIE_RELAY, SRC_XFMR_RELAY
  } out_src_t;
  localparam logic [31:0] OUT_CTRL_RST = 32'h09080000;
  localparam logic [16:0] SYNC_WIDTH_RST = 17'h00064;
  localparam logic [7:0] FILTER_RST = 8'h10;
endpackage

// File: sim/far_side_model.sv
// External equipment model: event sources, status levels, user inputs
`timescale 1ns/100ps
module far_side_model (
  input wire logic i_clk_sys,
  output logic [3:0] o_event,
  output logic [8:0] o_status,
  output logic [2:0] o_user
);
  initial
  begin
    o_event = 4'h0;
    o_status = 9'h000;
    o_user = 3'h0;
  end
  // Held several cycles so the two-flop synchroniser cannot miss it
  task automatic pulse(input int idx);
    @(posedge i_clk_sys);
    o_event[idx] <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    o_event[idx] <= 1'b0;
  endtask
  task automatic levels(input logic [8:0] st, input logic [2:0] usr);
    @(posedge i_clk_sys);
    o_status <= st;
    o_user <= usr;
  endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the auxiliary digital I/O block
`timescale 1ns/100ps
module testbench;
  logic i_clk_sys, i_rst, i_psel, i_penable, i_pwrite;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic o_pready, o_pslverr, o_strobe, o_phase_sync, s0;
  logic [2:0] o_input_rise, o_input_fall, usr;
  logic [3:0] o_user_output, ev;
  logic [8:0] st, e;
  logic [7:0] gpv [4] = '{8'h20, 8'h30, 8'h10, 8'h13};
  int n_mismatch, tests_run, n_rise, n_fall, len;

  aux_digital_io_strobe u_dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_transient_start(ev[0]),
    .i_relay_change(ev[1]), .i_param_change(ev[2]),
    .i_phase_a_zero(ev[3]), .i_user_input(usr),
    .i_output_enabled(st[0]), .i_phase_tie_config(st[1]),
    .i_fault(st[2]), .i_transient_active(st[3]),
    .i_program_running(st[4]), .i_remote(st[5]),
    .i_xfmr_coupling(st[6]), .i_tie_relay_cmd(st[7]),
    .i_xfmr_relay_cmd(st[8]), .o_strobe(o_strobe),
    .o_phase_sync(o_phase_sync), .o_input_rise(o_input_rise),
    .o_input_fall(o_input_fall), .o_user_output(o_user_output)
  );
  far_side_model u_far (
    .i_clk_sys(i_clk_sys),
    .o_event(ev),
    .o_status(st),
    .o_user(usr)
  );

  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    n_rise <= n_rise + $countones(o_input_rise);
    n_fall <= n_fall + $countones(o_input_fall);
  end

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (o_pready !== 1'b1 && n < 50);
    rd = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 50)
      n_mismatch++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask
  // Waits for the active level, then counts edges it is held
  task automatic width(input bit sy, input logic act, input int lim);
    int n;
    n = 0;
    len = 0;
    while (((sy ? o_phase_sync : o_strobe) !== act) && n < 20)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (((sy ? o_phase_sync : o_strobe) === act) && len < lim)
    begin
      @(posedge i_clk_sys);
      len++;
    end
  endtask
  task automatic strobe(input int idx, input int lim);
    fork
      u_far.pulse(idx);
      width(1'b0, 1'b1, lim);
    join
  endtask
  task automatic sync_w(input logic act);
    fork
      u_far.pulse(3);
      width(1'b1, act, 1000);
    join
    check("sync_width", 32'(len), 32'h00000177);
  endtask
  task automatic pulse_rst();
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (97000) @(posedge i_clk_sys);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rchk("strobe_ctrl", 8'h00, 32'h0);
    rchk("sync_w_rst", 8'h08, 32'h64);
    rchk("filter_rst", 8'h0C, 32'h10);
    rchk("out_ctrl_rst", 8'h14, 32'h09080000);
    wr(8'h1C, 32'hFFFFFFFF);
    rchk("unmapped", 8'h1C, 32'h0);
    check("pslverr", {31'h0, o_pslverr}, 32'h0);
    strobe(0, 300);
    check("strobe_off", 32'(len), 32'h0);
    wr(8'h00, 32'h1);
    strobe(1, 300);
    check("strobe_relay_off", 32'(len), 32'h0);
    strobe(0, 30000);
    check("strobe_tran", 32'(len), 32'h00005CC6);
    strobe(0, 12000);
    strobe(0, 30000);
    // Retrigger lands about 12000 cycles into the pulse, a few cycles after this count starts, hence the window
    check("retrigger", 32'(len >= 23750 && len <= 23762), 32'h1);
    wr(8'h00, 32'h6);
    strobe(2, 23800);
    check("strobe_param", 32'(len), 32'h00005CF8);
    pulse_rst();
    wr(8'h00, 32'h2);
    strobe(1, 200);
    check("strobe_relay", 32'(len), 32'h000000C8);
    pulse_rst();
    wr(8'h08, 32'h1);
    rchk("sync_min", 8'h08, 32'h3);
    wr(8'h08, 32'h1FFFF);
    rchk("sync_max", 8'h08, 32'h186A0);
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h1);
    sync_w(1'b1);
    wr(8'h04, 32'h3);
    repeat (2) @(posedge i_clk_sys);
    check("sync_idle_pol", {31'h0, o_phase_sync}, 32'h1);
    sync_w(1'b0);
    wr(8'h04, 32'h5);
    repeat (2) @(posedge i_clk_sys);
    s0 = o_phase_sync;
    u_far.pulse(3);
    repeat (10) @(posedge i_clk_sys);
    check("sync_auto", {31'h0, o_phase_sync}, {31'h0, ~s0});
    u_far.pulse(3);
    repeat (10) @(posedge i_clk_sys);
    check("sync_auto2", {31'h0, o_phase_sync}, {31'h0, s0});
    wr(8'h0C, 32'h4);
    u_far.levels(9'h0, 3'h7);
    u_far.levels(9'h0, 3'h0);
    repeat (20) @(posedge i_clk_sys);
    check("glitch", 32'(n_rise + n_fall), 32'h0);
    u_far.levels(9'h0, 3'h7);
    repeat (20) @(posedge i_clk_sys);
    check("rise", 32'(n_rise), 32'h3);
    rchk("in_status", 8'h10, 32'h7);
    u_far.levels(9'h0, 3'h0);
    repeat (20) @(posedge i_clk_sys);
    check("fall", 32'(n_fall), 32'h3);
    for (int s = 1; s < 10; s++)
    begin
      e = 9'h1 << (s - 1);
      wr(8'h14, 32'h09080000 | 32'(s));
      u_far.levels(e, 3'h0);
      repeat (3) @(posedge i_clk_sys);
      check("out_src", {28'h0, o_user_output},
            {28'h0, e[8], e[7], 2'h1});
      u_far.levels(9'h0, 3'h0);
      repeat (3) @(posedge i_clk_sys);
      check("out_src_low", {28'h0, o_user_output}, 32'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h14, 32'h09080000 | 32'(gpv[i]));
      repeat (3) @(posedge i_clk_sys);
      check("out_gp_inv", {31'h0, o_user_output[0]},
            {31'h0, gpv[i][5] ^ gpv[i][4]});
    end
    test_done();
  end
endmodule
